// ### sfe_pkg.sv
// Shared constants, types and command decoding for the serial flash front end.
// Assumes both link ends and the bench import it; no clock or reset here.
package sfe_pkg;
  // Array and address layout
  localparam int unsigned ADDR_BITS = 24;
  localparam int unsigned ARRAY_AW = 19;
  localparam int unsigned SECTOR_LSB = 12;
  localparam int unsigned HALF_LSB = 15;
  localparam int unsigned BLOCK_LSB = 16;
  // Instruction codes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_RD_SR2 = 8'h35;
  localparam logic [7:0] OP_WR_SR2 = 8'h31;
  // Second status register
  localparam int unsigned QE_BIT = 1;
  localparam logic QE_RESET = 1'h0;
  // Timing, at a 20 MHz core clock
  localparam int unsigned CORE_CLK_MHZ = 20;
  localparam int unsigned LINK_HALF_NS = 500;
  localparam int unsigned HOST_HALF_CYC = (LINK_HALF_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam int unsigned CS_GAP_HALVES = 4;
  // Buffering
  localparam int unsigned FIFO_W = 8;
  localparam int unsigned FIFO_D = 16;

  typedef enum logic [2:0] {
    SFE_IDLE = 3'h0,
    SFE_CMD = 3'h1,
    SFE_ADDR = 3'h3,
    SFE_DUMMY = 3'h2,
    SFE_DATA = 3'h6,
    SFE_END = 3'h7
  } sfe_state_t;

  typedef struct packed {
    logic ok;
    logic has_addr;
    logic [2:0] aw;
    logic [2:0] dw;
    logic [3:0] dummy;
    logic rd;
    logic quad;
  } sfe_cmd_t;

  // Lanes, address width, data width and dummy clocks of each instruction
  function automatic sfe_cmd_t sfe_cmd_info(input logic [7:0] op);
    sfe_cmd_t c;
    c = '{ok: 1'b1, has_addr: 1'b1, aw: 3'h1, dw: 3'h1, dummy: 4'h0, rd: 1'b1, quad: 1'b0};
    case (op)
      OP_READ: c.dummy = 4'h0;
      OP_FAST: c.dummy = 4'h8;
      OP_DUAL_OUT: begin c.dw = 3'h2; c.dummy = 4'h8; end
      OP_DUAL_IO: begin c.aw = 3'h2; c.dw = 3'h2; c.dummy = 4'h4; end
      OP_QUAD_OUT: begin c.dw = 3'h4; c.dummy = 4'h8; c.quad = 1'b1; end
      OP_QUAD_IO: begin c.aw = 3'h4; c.dw = 3'h4; c.dummy = 4'h6; c.quad = 1'b1; end
      OP_RD_SR2: c.has_addr = 1'b0;
      OP_WR_SR2: begin c.has_addr = 1'b0; c.rd = 1'b0; end
      default: c.ok = 1'b0;
    endcase
    return c;
  endfunction : sfe_cmd_info

  // Top bits of a byte spread over the lanes the device drives
  function automatic logic [3:0] sfe_dev_lanes(input logic [3:0] t, input logic [2:0] w);
    return (w == 3'h4) ? t : (w == 3'h2) ? {2'h0, t[3:2]} : {2'h0, t[3], 1'h0};
  endfunction : sfe_dev_lanes

  // Top bits of a word spread over the lanes the host drives
  function automatic logic [3:0] sfe_host_lanes(input logic [3:0] t, input logic [2:0] w);
    return (w == 3'h4) ? t : (w == 3'h2) ? {2'h0, t[3:2]} : {3'h0, t[3]};
  endfunction : sfe_host_lanes
endpackage : sfe_pkg

// ### sfe_link_if.sv
// Link between flash device end and host controller end.
// Resolves shared data lanes from the enables; undriven lanes read high (pull-up).
`timescale 1ns/1ps
interface sfe_link_if;
  logic sclk;
  logic cs_n;
  logic [3:0] host_dq_o;
  logic [3:0] host_dq_oe;
  logic [3:0] dev_dq_o;
  logic [3:0] dev_dq_oe;
  logic [3:0] dq;

  // Wire level of each lane
  assign dq = (dev_dq_oe & dev_dq_o) | (host_dq_oe & host_dq_o) | ~(dev_dq_oe | host_dq_oe);

  modport dev (input sclk, input cs_n, input dq, output dev_dq_o, output dev_dq_oe);
  modport host (output sclk, output cs_n, output host_dq_o, output host_dq_oe, input dq);
endinterface : sfe_link_if

// ### sfe_dev.sv
// Flash device end: serial front end sampling the host's clock, select and lanes.
// Assumes arst_n is the power-on reset and a fixed one-cycle array read latency.
`timescale 1ns/1ps
module sfe_dev
  import sfe_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  sfe_link_if.dev link,
  output logic rd_req,
  output logic [sfe_pkg::ARRAY_AW-1:0] rd_addr,
  input wire logic [7:0] rd_data,
  output logic [6:0] sector,
  output logic [3:0] half_block,
  output logic [2:0] block,
  output logic quad_enable_bit,
  output logic wp_active,
  output logic pause_active,
  output logic selected
);
  import sfe_pkg::*;

  localparam int unsigned NPIN = 6;
  localparam int unsigned CS_IX = 5;
  localparam int unsigned CK_IX = 4;

  logic [NPIN-1:0] s1_q, s2_q, s3_q, st_q, st_d;
  sfe_state_t state_q;
  logic [4:0] cnt_q;
  logic [23:0] sr_q;
  sfe_cmd_t info_q;
  logic qe_q;
  logic [ARRAY_AW-1:0] addr_q;
  logic [7:0] buf_q, sh_q;
  logic [3:0] bcnt_q;
  logic pend_q;
  logic [3:0] dout_q, doe_q;
  logic rd_req_q;
  logic [ARRAY_AW-1:0] rd_addr_q;
  logic [6:0] sector_q;
  logic [3:0] half_q;
  logic [2:0] block_q;
  logic wp_q, pause_q, sel_q;

  // Pin edges and lane decode
  wire logic [NPIN-1:0] agree = ~(s2_q ^ s3_q);
  wire logic sclk_rise = st_d[CK_IX] & ~st_q[CK_IX];
  wire logic sclk_fall = ~st_d[CK_IX] & st_q[CK_IX];
  wire logic cs_fall = ~st_d[CS_IX] & st_q[CS_IX];
  wire logic cs_high = st_d[CS_IX];
  wire logic [3:0] dq_in = st_d[3:0];
  wire logic [2:0] in_w = (state_q == SFE_ADDR) ? info_q.aw : 3'h1;
  wire logic [3:0] in_bits = (in_w == 3'h4) ? dq_in : (in_w == 3'h2) ? {2'h0, dq_in[1:0]} : {3'h0, dq_in[0]};
  wire logic [23:0] sr_n = (sr_q << in_w) | {20'h0, in_bits};
  wire logic [4:0] cnt_n = cnt_q + {2'h0, in_w};
  wire sfe_cmd_t op_info = sfe_cmd_info(sr_n[7:0]);
  wire logic [ARRAY_AW-1:0] addr_n = sr_n[ARRAY_AW-1:0];
  wire logic load = (bcnt_q == 4'h0);
  wire logic [7:0] sh_n = load ? buf_q : (sh_q << info_q.dw);
  wire logic [3:0] bcnt_n = (load ? 4'h8 : bcnt_q) - {1'h0, info_q.dw};
  wire logic [ARRAY_AW-1:0] fetch_addr = (state_q == SFE_ADDR) ? addr_n : addr_q + 19'h1;
  wire logic fetch = info_q.has_addr &&
    ((state_q == SFE_ADDR && sclk_rise && cnt_n == 5'(ADDR_BITS)) ||
     (state_q == SFE_DATA && info_q.rd && sclk_fall && load));

  // Stable pin value once the second and third stages agree
  assign st_d = (agree & s3_q) | (~agree & st_q);

  // Three-stage pin synchroniser; select starts low so a low pin needs a fall
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
    end
    else
    begin
      s1_q <= {link.cs_n, link.sclk, link.dq};
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= st_d;
    end
  end

  // Instruction, address, dummy and data sequencing
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= SFE_IDLE;
      cnt_q <= '0;
      sr_q <= '0;
      info_q <= '0;
      qe_q <= QE_RESET;
    end
    else if (cs_high)
    begin
      state_q <= SFE_IDLE;
      cnt_q <= '0;
    end
    else
    begin
      case (state_q)
        SFE_IDLE:
          if (cs_fall)
          begin
            state_q <= SFE_CMD;
            cnt_q <= '0;
          end
        SFE_CMD:
          if (sclk_rise)
          begin
            sr_q <= sr_n;
            cnt_q <= cnt_n;
            if (cnt_n == 5'h8)
            begin
              info_q <= op_info;
              cnt_q <= '0;
              if (!op_info.ok || (op_info.quad && !qe_q))
                state_q <= SFE_END;
              else if (op_info.has_addr)
                state_q <= SFE_ADDR;
              else
                state_q <= SFE_DATA;
            end
          end
        SFE_ADDR:
          if (sclk_rise)
          begin
            sr_q <= sr_n;
            cnt_q <= cnt_n;
            if (cnt_n == 5'(ADDR_BITS))
            begin
              cnt_q <= '0;
              state_q <= (info_q.dummy != 4'h0) ? SFE_DUMMY : SFE_DATA;
            end
          end
        SFE_DUMMY:
          if (sclk_rise)
          begin
            cnt_q <= cnt_q + 5'h1;
            if (cnt_q + 5'h1 == {1'h0, info_q.dummy})
              state_q <= SFE_DATA;
          end
        SFE_DATA:
          if (sclk_rise && !info_q.rd)
          begin
            sr_q <= sr_n;
            cnt_q <= cnt_n;
            if (cnt_n == 5'h8)
            begin
              qe_q <= sr_n[QE_BIT];
              state_q <= SFE_END;
            end
          end
        SFE_END: state_q <= SFE_END;
        default: state_q <= SFE_IDLE;
      endcase
    end
  end

  // Read address and array prefetch into a one-byte buffer
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_q <= '0;
      rd_req_q <= 1'b0;
      rd_addr_q <= '0;
      pend_q <= 1'b0;
      buf_q <= '0;
    end
    else
    begin
      rd_req_q <= fetch;
      pend_q <= rd_req_q;
      if (fetch)
      begin
        addr_q <= fetch_addr;
        rd_addr_q <= fetch_addr;
      end
      if (pend_q)
        buf_q <= rd_data;
      else if (state_q == SFE_CMD && cnt_n == 5'h8 && sclk_rise && !cs_high)
        buf_q <= {6'h0, qe_q, 1'h0};
    end
  end

  // Output shifter: new lanes after each falling edge, released when deselected
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sh_q <= '0;
      bcnt_q <= '0;
      dout_q <= '0;
      doe_q <= '0;
    end
    else if (cs_high || state_q != SFE_DATA || !info_q.rd)
    begin
      bcnt_q <= '0;
      doe_q <= '0;
    end
    else if (sclk_fall)
    begin
      sh_q <= sh_n;
      bcnt_q <= bcnt_n;
      dout_q <= sfe_dev_lanes(sh_n[7:4], info_q.dw);
      doe_q <= sfe_dev_lanes(4'hF, info_q.dw);
    end
  end

  // Array organisation and pin-function status
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sector_q <= '0;
      half_q <= '0;
      block_q <= '0;
      wp_q <= 1'b0;
      pause_q <= 1'b0;
      sel_q <= 1'b0;
    end
    else
    begin
      if (fetch)
      begin
        sector_q <= 7'(fetch_addr >> SECTOR_LSB);
        half_q <= 4'(fetch_addr >> HALF_LSB);
        block_q <= 3'(fetch_addr >> BLOCK_LSB);
      end
      wp_q <= !qe_q && !dq_in[2];
      pause_q <= !qe_q && !dq_in[3] && !cs_high;
      sel_q <= (state_q != SFE_IDLE) && !cs_high;
    end
  end

  assign link.dev_dq_o = dout_q;
  assign link.dev_dq_oe = doe_q;
  assign rd_req = rd_req_q;
  assign rd_addr = rd_addr_q;
  assign sector = sector_q;
  assign half_block = half_q;
  assign block = block_q;
  assign quad_enable_bit = qe_q;
  assign wp_active = wp_q;
  assign pause_active = pause_q;
  assign selected = sel_q;
endmodule : sfe_dev

// ### sfe_host.sv
// Host controller end: makes the serial clock, drives select and lanes,
// and buffers read bytes in a FIFO; a full FIFO stalls the serial clock.
`timescale 1ns/1ps
module sfe_fifo
  import sfe_pkg::*;
#(
  parameter int unsigned W = FIFO_W,
  parameter int unsigned D = FIFO_D
)
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  import sfe_pkg::*;
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_q, rp_q;
  logic [AW:0] cnt_q;
  logic full_q, ne_q;

  // Transfer decode
  wire logic push = in_valid && !full_q;
  wire logic pop = out_valid && out_ready;
  wire logic [AW:0] cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

  // Pointers and registered flags
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      full_q <= 1'b0;
      ne_q <= 1'b0;
    end
    else
    begin
      wp_q <= wp_q + AW'(push);
      rp_q <= rp_q + AW'(pop);
      cnt_q <= cnt_d;
      full_q <= (cnt_d == (AW+1)'(D));
      ne_q <= (cnt_d != '0);
    end
  end

  // Storage
  always_ff @(posedge core_clk)
  begin
    if (push)
      mem[wp_q] <= in_data;
  end

  assign in_ready = !full_q;
  assign out_valid = ne_q;
  assign out_data = mem[rp_q];
endmodule : sfe_fifo

module sfe_host
  import sfe_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  sfe_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_op,
  input wire logic [sfe_pkg::ADDR_BITS-1:0] req_addr,
  input wire logic [7:0] req_len,
  input wire logic [7:0] req_wdata,
  input wire logic req_cpol,
  output logic req_refused,
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [7:0] rd_data
);
  import sfe_pkg::*;

  logic [3:0] s1_q, s2_q, s3_q, st_q;
  sfe_state_t state_q;
  sfe_cmd_t info_q;
  logic [4:0] div_q, cnt_q;
  logic [2:0] gap_q;
  logic [31:0] tx_q;
  logic [7:0] rx_q, len_q;
  logic [3:0] rxn_q, dout_q, doe_q;
  logic sclk_q, cs_n_q, cpol_q, qe_q, rdy_q, ref_q, push_q;

  wire logic [3:0] agree = ~(s2_q ^ s3_q);
  wire logic [3:0] dq_st = (agree & s3_q) | (~agree & st_q);
  wire sfe_cmd_t req_info = sfe_cmd_info(req_op);
  wire logic bad_req = !req_info.ok || (req_info.quad && !qe_q) || (req_info.rd && req_len == 8'h0);
  wire logic rx_mode = (state_q == SFE_DATA) && info_q.rd;
  wire logic [2:0] w = (state_q == SFE_ADDR) ? info_q.aw : rx_mode ? info_q.dw : 3'h1;
  wire logic [3:0] rx_bits = (w == 3'h4) ? dq_st : (w == 3'h2) ? {2'h0, dq_st[1:0]} : {3'h0, dq_st[1]};
  wire logic [3:0] rxn_n = rxn_q + {1'h0, w};
  wire logic [4:0] cnt_n = cnt_q + ((state_q == SFE_ADDR) ? {2'h0, w} : 5'h1);
  wire logic f_rdy;
  wire logic stall = rx_mode && !sclk_q && rxn_n == 4'h8 && !f_rdy;
  wire logic tick = (div_q == 5'(HOST_HALF_CYC - 1)) && !stall;
  wire logic rise = tick && !sclk_q && state_q != SFE_END && state_q != SFE_IDLE;
  wire logic fall = tick && sclk_q && state_q != SFE_END && state_q != SFE_IDLE;
  wire logic start = (state_q == SFE_IDLE) && req_valid && rdy_q && !bad_req;

  // Lane synchroniser for the device's data
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      st_q <= '0;
    end
    else
    begin
      s1_q <= link.dq;
      s2_q <= s1_q;
      s3_q <= s2_q;
      st_q <= dq_st;
    end
  end

  // Half-period divider and idle select gap
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      div_q <= '0;
      gap_q <= '0;
    end
    else
    begin
      if (start)
        div_q <= '0; // First level after select falls is a full half period
      else if (!stall)
        div_q <= tick ? 5'h0 : div_q + 5'h1;
      if (state_q != SFE_IDLE)
        gap_q <= '0;
      else if (tick && gap_q != 3'(CS_GAP_HALVES))
        gap_q <= gap_q + 3'h1;
    end
  end

  // Transaction sequencer: shift on rise, drive lanes on fall
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_q <= SFE_IDLE;
      info_q <= '0;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      cpol_q <= 1'b0;
      qe_q <= QE_RESET;
      rdy_q <= 1'b0;
      ref_q <= 1'b0;
      push_q <= 1'b0;
      tx_q <= '0;
      rx_q <= '0;
      rxn_q <= '0;
      len_q <= '0;
      cnt_q <= '0;
      dout_q <= '0;
      doe_q <= '0;
    end
    else
    begin
      ref_q <= 1'b0;
      push_q <= 1'b0;
      rdy_q <= (state_q == SFE_IDLE) && gap_q == 3'(CS_GAP_HALVES) && !(req_valid && rdy_q);
      case (state_q)
        SFE_IDLE:
          if (req_valid && rdy_q)
          begin
            if (bad_req)
              ref_q <= 1'b1;
            else
            begin
              state_q <= SFE_CMD;
              info_q <= req_info;
              cpol_q <= req_cpol;
              sclk_q <= req_cpol;
              cs_n_q <= 1'b0;
              tx_q <= {req_op, req_addr};
              len_q <= req_len;
              cnt_q <= '0;
              rxn_q <= '0;
              dout_q <= {3'h0, req_op[7]};
              doe_q <= 4'h1;
            end
          end
        SFE_END:
          if (tick)
          begin
            if (sclk_q != cpol_q)
              sclk_q <= cpol_q;
            else
            begin
              cs_n_q <= 1'b1;
              doe_q <= '0;
              state_q <= SFE_IDLE;
            end
          end
        default:
          if (rise)
          begin
            sclk_q <= 1'b1;
            tx_q <= tx_q << w;
            cnt_q <= cnt_n;
            if (state_q == SFE_CMD && cnt_n == 5'h8)
            begin
              cnt_q <= '0;
              state_q <= info_q.has_addr ? SFE_ADDR : SFE_DATA;
              if (!info_q.has_addr)
              begin
                tx_q <= {req_wdata, 24'h0};
                rx_q <= req_wdata; // Whole copy; tx_q shifts its bits out
              end
            end
            else if (state_q == SFE_ADDR && cnt_n == 5'(ADDR_BITS))
            begin
              cnt_q <= '0;
              state_q <= (info_q.dummy != 4'h0) ? SFE_DUMMY : SFE_DATA;
            end
            else if (state_q == SFE_DUMMY && cnt_n == {1'h0, info_q.dummy})
              state_q <= SFE_DATA;
            else if (state_q == SFE_DATA && !info_q.rd && cnt_n == 5'h8)
            begin
              qe_q <= rx_q[QE_BIT];
              state_q <= SFE_END;
            end
            else if (rx_mode)
            begin
              rx_q <= (rx_q << w) | {4'h0, rx_bits};
              rxn_q <= (rxn_n == 4'h8) ? 4'h0 : rxn_n;
              if (rxn_n == 4'h8)
              begin
                push_q <= 1'b1;
                len_q <= len_q - 8'h1;
                if (len_q == 8'h1)
                  state_q <= SFE_END;
              end
            end
          end
          else if (fall)
          begin
            sclk_q <= 1'b0;
            dout_q <= (state_q == SFE_DUMMY) ? 4'h0 : sfe_host_lanes(tx_q[31:28], w);
            doe_q <= rx_mode ? 4'h0 : sfe_host_lanes(4'hF, w);
          end
      endcase
    end
  end

  // Read byte buffer; full stalls the serial clock
  sfe_fifo #(.W(FIFO_W), .D(FIFO_D)) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(push_q),
    .in_ready(f_rdy),
    .in_data(rx_q),
    .out_valid(rd_valid),
    .out_ready(rd_ready),
    .out_data(rd_data)
  );

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.host_dq_o = dout_q;
  assign link.host_dq_oe = doe_q;
  assign req_ready = rdy_q;
  assign req_refused = ref_q;
endmodule : sfe_host

// ### sfe_link_chk.sv
// Checker for the serial link between device end and host end.
// Assumes the link signals as plain inputs, one core clock domain.
`timescale 1ns/1ps
module sfe_link_chk
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] host_dq_o,
  input wire logic [3:0] host_dq_oe,
  input wire logic [3:0] dev_dq_o,
  input wire logic [3:0] dev_dq_oe,
  input wire logic [3:0] dq
);
  logic sclk_q;
  logic [7:0] nrise_q;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);
  // Counts clock rises inside a frame
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sclk_q <= 1'b0;
      nrise_q <= 8'h00;
    end
    else
    begin
      sclk_q <= sclk;
      if (cs_n)
        nrise_q <= 8'h00;
      else if (sclk && !sclk_q && nrise_q != 8'hFF)
        nrise_q <= nrise_q + 8'h01;
    end
  end
  // Lane ownership and clock timing
  a_desel_quiet: assert property (cs_n [*8] |-> dev_dq_oe == 4'h0)
    else $error("device drives lanes while deselected");
  a_one_owner: assert property ((dev_dq_oe & host_dq_oe) == 4'h0)
    else $error("both ends drive one lane");
  a_half_period: assert property ($changed(sclk) |=> $stable(sclk) [*8])
    else $error("serial clock level too short");
  a_op_host: assert property (!cs_n && nrise_q < 8'h08 |-> host_dq_oe == 4'h1)
    else $error("instruction not on lane 0 alone");
  a_op_listen: assert property (!cs_n && nrise_q < 8'h08 |-> dev_dq_oe == 4'h0)
    else $error("device drives during instruction");
  a_dev_on_fall: assert property ($changed(dev_dq_o) && dev_dq_oe != 4'h0 |-> !sclk && !$past(sclk, 3))
    else $error("device data changed off a falling clock");
  a_host_on_fall: assert property (!cs_n && !$past(cs_n) && $changed(host_dq_o) |-> !sclk)
    else $error("host data changed while clock high");
  a_end_still: assert property ($rose(cs_n) |-> $stable(sclk) [*4])
    else $error("clock moved at frame end");
endmodule : sfe_link_chk

// ### serial_flash_spi_front_end_bench.sv
// Bench: host end and device end joined by the link, driven from the request port.
// Assumes a 20 MHz core clock and an array model with one cycle of read latency.
`timescale 1ns/1ps
module serial_flash_spi_front_end_bench;
  import sfe_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_cpol = 1'b0;
  logic rd_ready = 1'b1;
  logic [7:0] req_op = 8'h00;
  logic [7:0] req_len = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic [7:0] arr_data = 8'h00;
  logic [7:0] status_exp = 8'h00;
  logic [23:0] req_addr = 24'h000000;
  logic req_ready, req_refused, rd_valid, arr_req, quad_enable_bit, wp_active, pause_active, selected;
  logic [7:0] rd_data;
  logic [18:0] arr_addr;
  logic [6:0] sector;
  logic [3:0] half_block;
  logic [2:0] block;
  logic [7:0] got[$];
  int n_errors = 0;
  int total_checks = 0;
  int n_ref = 0;
  sfe_link_if u_sfe_link_if();
  sfe_dev u_sfe_dev (.core_clk(core_clk), .arst_n(arst_n), .link(u_sfe_link_if), .rd_req(arr_req),
    .rd_addr(arr_addr), .rd_data(arr_data), .sector(sector), .half_block(half_block), .block(block),
    .quad_enable_bit(quad_enable_bit), .wp_active(wp_active), .pause_active(pause_active), .selected(selected));
  sfe_host u_sfe_host (.core_clk(core_clk), .arst_n(arst_n), .link(u_sfe_link_if), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_len(req_len), .req_wdata(req_wdata),
    .req_cpol(req_cpol), .req_refused(req_refused), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));
  sfe_link_chk u_sfe_link_chk (.core_clk(core_clk), .arst_n(arst_n), .sclk(u_sfe_link_if.sclk),
    .cs_n(u_sfe_link_if.cs_n), .host_dq_o(u_sfe_link_if.host_dq_o), .host_dq_oe(u_sfe_link_if.host_dq_oe),
    .dev_dq_o(u_sfe_link_if.dev_dq_o), .dev_dq_oe(u_sfe_link_if.dev_dq_oe), .dq(u_sfe_link_if.dq));
  // Core clock, 50 ns period
  always #25 core_clk = ~core_clk;
  // Array contents as a pattern of the address
  function automatic logic [7:0] mem(input logic [18:0] a);
    return a[7:0] ^ {1'b0, a[18:12]};
  endfunction : mem
  // Array model and capture of bytes and refusals
  always @(posedge core_clk)
  begin
    if (arr_req === 1'b1)
      arr_data <= mem(arr_addr);
    if (rd_valid === 1'b1 && rd_ready)
      got.push_back(rd_data);
    if (req_refused === 1'b1)
      n_ref++;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic close_out;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : close_out
  // One request on the host port, waits for completion
  task automatic run(input logic [7:0] op, input logic [23:0] a, input logic [7:0] len, input logic [7:0] wd,
    input logic cpol);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 30000)
    begin
      @(negedge core_clk);
      n++;
    end
    req_valid = 1'b1;
    req_op = op;
    req_addr = a;
    req_len = len;
    req_wdata = wd;
    req_cpol = cpol;
    @(negedge core_clk);
    req_valid = 1'b0;
    @(negedge core_clk);
    n = 0;
    while (req_ready !== 1'b1 && n < 30000)
    begin
      @(negedge core_clk);
      n++;
    end
    chk(req_ready, 1'b1);
  endtask : run
  task automatic rdchk(input logic [7:0] op, input logic [23:0] a, input logic [7:0] len, input logic cpol);
    got.delete();
    run(op, a, len, 8'h00, cpol);
    repeat (3) @(negedge core_clk);
    chk(got.size(), len);
    foreach (got[i])
      chk(got[i], (op == OP_RD_SR2) ? status_exp : mem(a[18:0] + 19'(i)));
  endtask : rdchk
  task automatic t_reset_quiet;
    chk(u_sfe_link_if.cs_n, 1'b1);
    chk(u_sfe_link_if.dev_dq_oe, 4'h0);
    chk(selected, 1'b0);
  endtask : t_reset_quiet
  task automatic t_modes;
    logic [7:0] ops [4];
    ops = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_DUAL_IO};
    for (int k = 0; k < 4; k++)
      rdchk(ops[k], {4'h0, k[3:0], 16'hFFFE}, 8'h04, k[0]);
  endtask : t_modes
  task automatic t_geom(input logic [23:0] a, input logic [6:0] s, input logic [3:0] h, input logic [2:0] b);
    rdchk(OP_READ, a, 8'h01, 1'b0);
    chk(sector, s);
    chk(half_block, h);
    chk(block, b);
  endtask : t_geom
  task automatic t_refuse;
    int r;
    r = n_ref;
    run(8'hFF, 24'h000000, 8'h01, 8'h00, 1'b0);
    run(OP_READ, 24'h000000, 8'h00, 8'h00, 1'b0);
    run(OP_QUAD_IO, 24'h000000, 8'h04, 8'h00, 1'b0);
    chk(n_ref - r, 3);
  endtask : t_refuse
  task automatic t_quad;
    run(OP_WR_SR2, 24'h000000, 8'h01, 8'h02, 1'b0);
    chk(quad_enable_bit, 1'b1);
    chk(wp_active, 1'b0);
    chk(pause_active, 1'b0);
    status_exp = 8'h02;
    rdchk(OP_RD_SR2, 24'h000000, 8'h02, 1'b0);
    rdchk(OP_QUAD_OUT, 24'h03FFFC, 8'h06, 1'b0);
    rdchk(OP_QUAD_IO, 24'h047FFE, 8'h06, 1'b1);
  endtask : t_quad
  // Full buffer stalls the link with the clock low, then drains
  task automatic t_stall;
    got.delete();
    rd_ready = 1'b0;
    fork
      run(OP_FAST, 24'h010000, 8'h14, 8'h00, 1'b0);
    join_none
    repeat (5000) @(negedge core_clk);
    chk(u_sfe_link_if.sclk, 1'b0);
    chk(selected, 1'b1);
    chk(got.size(), 0);
    rd_ready = 1'b1;
    wait fork;
    repeat (3) @(negedge core_clk);
    chk(got.size(), 20);
    foreach (got[i])
      chk(got[i], mem(19'h10000 + 19'(i)));
    chk(rd_valid, 1'b0);
  endtask : t_stall
  task automatic t_reset_mid;
    fork
      run(OP_READ, 24'h000100, 8'h08, 8'h00, 1'b0);
    join_none
    repeat (1200) @(negedge core_clk);
    arst_n = 1'b0;
    disable fork;
    @(negedge core_clk);
    chk(u_sfe_link_if.dev_dq_oe, 4'h0);
    chk(quad_enable_bit, 1'b0);
    repeat (5) @(negedge core_clk);
    arst_n = 1'b1;
    status_exp = 8'h00;
    rdchk(OP_RD_SR2, 24'h000000, 8'h01, 1'b0);
  endtask : t_reset_mid
  // Main sequence
  initial
  begin
    repeat (3) @(negedge core_clk);
    t_reset_quiet();
    repeat (3) @(negedge core_clk);
    arst_n = 1'b1;
    t_modes();
    // Last prefetch of a one-byte mode 0 read lands two bytes on
    t_geom(24'h007FFE, 7'h08, 4'h1, 3'h0);
    t_geom(24'h068FFE, 7'h69, 4'hD, 3'h6);
    t_geom(24'h07FFFD, 7'h7F, 4'hF, 3'h7);
    t_refuse();
    t_quad();
    t_stall();
    t_reset_mid();
    close_out();
  end
  // Watchdog against a hung link
  initial
  begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    close_out();
  end
endmodule : serial_flash_spi_front_end_bench
